// *** hw/tcr_pkg.sv ***
// package for the transaction checkpoint and restore block
package tcr_pkg;

  typedef enum logic [2:0] {
    TCR_IDLE, TCR_BAR_IN, TCR_SAVE, TCR_TX, TCR_BAR_OUT, TCR_RESTORE
  } tcr_state_e;

  // register byte offsets
  localparam logic [4:0] TCR_OFF_CTRL    = 5'h00;
  localparam logic [4:0] TCR_OFF_STATUS  = 5'h04;
  localparam logic [4:0] TCR_OFF_CAUSE   = 5'h08;
  localparam logic [4:0] TCR_OFF_COMMITS = 5'h0C;
  localparam logic [4:0] TCR_OFF_FAILS   = 5'h10;
  localparam logic [1:0] TCR_CTRL_RESET  = 2'h1;
  localparam int         TCR_CTRL_ZERO_UP = 0;
  localparam int         TCR_CTRL_CLR_FAIL = 1;

  // checkpoint item numbering, one slot per saved register
  localparam logic [6:0] TCR_ITEM_SP        = 7'h1F;
  localparam logic [6:0] TCR_ITEM_VEC0      = 7'h25;
  localparam logic [6:0] TCR_ITEM_PRED0     = 7'h45;
  localparam logic [6:0] TCR_ITEM_LAST_BASE = 7'h22;
  localparam logic [6:0] TCR_ITEM_LAST_SIMD = 7'h44;
  localparam logic [6:0] TCR_ITEM_LAST_SVE  = 7'h55;
  localparam int         TCR_ITEM_COUNT     = 86;

  // failure cause layout
  localparam int TCR_CAUSE_RTRY = 15;
  localparam int TCR_CAUSE_CNCL = 16;
  localparam int TCR_CAUSE_MEM  = 17;
  localparam int TCR_CAUSE_NEST = 21;
  localparam logic [7:0] TCR_DEPTH_MAX = 8'hFF;
  localparam int TCR_SIMD_BITS  = 128;

endpackage : tcr_pkg

// *** hw/tcr_core.sv ***
// transaction checkpoint, restore and exit sequencing for one core
`timescale 1ns/1ps
module tcr_core #(
  parameter int VL_MAX        = 256,
  parameter bit SYSREG_IN_CKPT = 1'b0
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // avalon-mm register slave
  input  wire logic [4:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  // instruction events from the core
  input  wire logic                      begin_instr,
  input  wire logic [4:0]                begin_dest,
  input  wire logic [63:0]               begin_pc,
  input  wire logic                      commit_instr,
  input  wire logic                      commit_order_viol,
  input  wire logic                      abort_instr,
  input  wire logic [15:0]               abort_imm,
  input  wire logic                      fail_req,
  input  wire logic [63:0]               fail_cause,
  input  wire logic                      mem_conflict,
  input  wire logic                      fp_enabled,
  input  wire logic                      sve_enabled,
  input  wire logic [11:0]               cur_vl,
  output logic                           busy,
  output logic                           in_tx,
  output logic [7:0]                     nest_depth,
  output logic                           resume_vld,
  output logic [63:0]                    resume_pc,
  // register file access
  output logic                           rf_rd_en,
  output logic [6:0]                     rf_rd_idx,
  input  wire logic [VL_MAX-1:0]         rf_rd_data,
  output logic                           rf_wr_en,
  output logic [6:0]                     rf_wr_idx,
  output logic [VL_MAX-1:0]              rf_wr_data,
  // stack pointer select guard
  input  wire logic                      stack_pointer_select_wr_req,
  output logic                           stack_pointer_select_wr_grant,
  // memory system and monitors
  output logic                           mem_barrier_req,
  input  wire logic                      mem_barrier_ack,
  output logic                           tx_order_active,
  output logic                           store_drain,
  output logic                           store_discard,
  output logic                           gmon_others_clr,
  output logic                           lmon_open,
  output logic                           gmon_self_open,
  input  wire logic                      own_gmon_excl,
  output logic                           event_set
);
  import tcr_pkg::*;

  typedef struct packed {
    tcr_state_e        state;
    logic [7:0]        depth;
    logic [6:0]        idx;
    logic [6:0]        last_idx;
    logic              issue_done;
    logic              cap_vld;
    logic [6:0]        cap_idx;
    logic [4:0]        dest;
    logic [63:0]       pc;
    logic              sve_mode;
    logic [63:0]       cause;
    logic              bar_req;
    logic              rf_wr_en;
    logic [6:0]        rf_wr_idx;
    logic [VL_MAX-1:0] rf_wr_data;
    logic              resume_vld;
    logic              drain;
    logic              discard;
    logic              gclr;
    logic              lmon;
    logic              gself;
    logic              evt;
    logic [1:0]        ctrl;
    logic [31:0]       commits;
    logic [31:0]       fails;
    logic              av_ack;
    logic [31:0]       av_rdata;
  } tcr_state_s;

  tcr_state_s q;
  tcr_state_s d;

  // saved entry values, one slot per checkpoint item
  // sysreg group excluded
  // no slot exists for the optional system register group, so SYSREG_IN_CKPT
  // must stay clear; enabling it needs extra slots and item numbers first
  // read combinationally during restore: no extra pipeline stage, at the cost of a wide mux
  logic [VL_MAX-1:0] ckpt_mem [TCR_ITEM_COUNT];

  logic              fail_go;
  logic [63:0]       fail_val;
  logic [31:0]       vl_lim;
  logic [VL_MAX-1:0] keep_mask;
  logic [VL_MAX-1:0] entry_val;
  logic              is_vec;
  logic              is_pred;

  // restore masking of bits above the live vector length
  always_comb begin
    entry_val = ckpt_mem[q.idx];
    is_vec    = (q.idx >= TCR_ITEM_VEC0) && (q.idx < TCR_ITEM_PRED0);
    is_pred   = (q.idx >= TCR_ITEM_PRED0);
    vl_lim    = q.sve_mode ? 32'(cur_vl) : 32'(TCR_SIMD_BITS);
    // predicates hold one bit per vector byte
    if (is_pred) begin
      vl_lim = vl_lim >> 3;
    end
    for (int i = 0; i < VL_MAX; i++) begin
      keep_mask[i] = (i < vl_lim);
    end
    if (!q.ctrl[TCR_CTRL_ZERO_UP] || !(is_vec || is_pred)) begin
      keep_mask = '1;
    end
  end

  // failure source selection; the instruction cause wins over async ones
  always_comb begin
    fail_go  = 1'b0;
    fail_val = 64'h0000_0000_0000_0000;
    if (q.state == TCR_TX) begin
      if (abort_instr) begin
        fail_go  = 1'b1;
        fail_val[14:0] = abort_imm[14:0];
        fail_val[TCR_CAUSE_RTRY] = abort_imm[15];
        fail_val[TCR_CAUSE_CNCL] = 1'b1;
      end else if (begin_instr && q.depth == TCR_DEPTH_MAX) begin
        fail_go  = 1'b1;
        fail_val[TCR_CAUSE_NEST] = 1'b1;
      end else if (commit_instr && q.depth == 8'h01 && commit_order_viol) begin
        fail_go  = 1'b1;
        fail_val[TCR_CAUSE_MEM]  = 1'b1;
        fail_val[TCR_CAUSE_RTRY] = 1'b1;
      end else if (fail_req) begin
        fail_go  = 1'b1;
        fail_val = fail_cause;
        fail_val[TCR_CAUSE_CNCL] = 1'b0;
        fail_val[14:0] = 15'h0000;
      end else if (mem_conflict) begin
        fail_go  = 1'b1;
        fail_val[TCR_CAUSE_MEM]  = 1'b1;
        fail_val[TCR_CAUSE_RTRY] = 1'b1;
      end
    end
  end

  // next-state logic for the whole block
  always_comb begin
    d            = q;
    d.cap_vld    = 1'b0;
    d.rf_wr_en   = 1'b0;
    d.resume_vld = 1'b0;
    d.drain      = 1'b0;
    d.discard    = 1'b0;
    d.gclr       = 1'b0;
    d.lmon       = 1'b0;
    d.gself      = 1'b0;
    d.evt        = 1'b0;
    case (q.state)
      TCR_IDLE: begin
        if (begin_instr) begin
          d.dest     = begin_dest;
          d.pc       = begin_pc;
          d.sve_mode = fp_enabled && sve_enabled;
          d.last_idx = TCR_ITEM_LAST_BASE;
          if (fp_enabled) begin
            d.last_idx = sve_enabled ? TCR_ITEM_LAST_SVE : TCR_ITEM_LAST_SIMD;
          end
          d.idx        = 7'h00;
          d.issue_done = 1'b0;
          d.bar_req    = 1'b1;
          d.state      = TCR_BAR_IN;
        end
      end
      TCR_BAR_IN: begin
        if (mem_barrier_ack) begin
          d.bar_req = 1'b0;
          d.state   = TCR_SAVE;
        end
      end
      TCR_SAVE: begin
        if (!q.issue_done) begin
          d.cap_vld = 1'b1;
          d.cap_idx = q.idx;
          if (q.idx == q.last_idx) begin
            d.issue_done = 1'b1;
          end else begin
            d.idx = q.idx + 7'h01;
          end
        end else if (!q.cap_vld) begin
          d.lmon  = 1'b1;
          d.gself = 1'b1;
          d.evt   = own_gmon_excl;
          d.depth = 8'h01;
          d.state = TCR_TX;
        end
      end
      TCR_TX: begin
        if (fail_go) begin
          d.discard = 1'b1;
          d.gclr    = q.ctrl[TCR_CTRL_CLR_FAIL];
          d.lmon    = 1'b1;
          d.gself   = 1'b1;
          d.evt     = own_gmon_excl;
          d.cause   = fail_val;
          d.fails   = q.fails + 32'h0000_0001;
          d.idx     = 7'h00;
          d.state   = TCR_RESTORE;
        end else if (begin_instr) begin
          d.depth = q.depth + 8'h01;
        end else if (commit_instr) begin
          if (q.depth == 8'h01) begin
            d.bar_req = 1'b1;
            d.state   = TCR_BAR_OUT;
          end else begin
            d.depth = q.depth - 8'h01;
          end
        end
      end
      TCR_BAR_OUT: begin
        if (mem_barrier_ack) begin
          d.bar_req = 1'b0;
          d.drain   = 1'b1;
          d.gclr    = 1'b1;
          d.lmon    = 1'b1;
          d.gself   = 1'b1;
          d.evt     = own_gmon_excl;
          d.depth   = 8'h00;
          d.commits = q.commits + 32'h0000_0001;
          d.state   = TCR_IDLE;
        end
      end
      TCR_RESTORE: begin
        d.rf_wr_en   = 1'b1;
        d.rf_wr_idx  = q.idx;
        d.rf_wr_data = entry_val & keep_mask;
        if (q.idx == 7'(q.dest)) begin
          d.rf_wr_data = VL_MAX'(q.cause);
        end
        // last write and resume pulse leave on the same edge, so the core
        // may restart while the final item lands; the file takes it in that cycle
        if (q.idx == q.last_idx) begin
          d.depth      = 8'h00;
          d.resume_vld = 1'b1;
          d.state      = TCR_IDLE;
        end else begin
          d.idx = q.idx + 7'h01;
        end
      end
      default: begin
        d.state = TCR_IDLE;
      end
    endcase

    // register slave: one wait cycle, answer on the second
    d.av_ack = (avs_read || avs_write) && !q.av_ack;
    if (avs_read && !q.av_ack) begin
      case (avs_address)
        TCR_OFF_CTRL:    d.av_rdata = {30'h0000_0000, q.ctrl};
        TCR_OFF_STATUS:  d.av_rdata = {20'h0_0000, q.depth, 1'b0, q.state};
        TCR_OFF_CAUSE:   d.av_rdata = q.cause[31:0];
        TCR_OFF_COMMITS: d.av_rdata = q.commits;
        TCR_OFF_FAILS:   d.av_rdata = q.fails;
        default:         d.av_rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write && q.av_ack && avs_address == TCR_OFF_CTRL && avs_byteenable[0]) begin
      d.ctrl = avs_writedata[1:0];
    end
  end

  // state register; reset takes constants only
  always_ff @(posedge clk) begin
    if (rst) begin
      q            <= '0;
      q.state      <= TCR_IDLE;
      q.ctrl       <= TCR_CTRL_RESET;
    end else begin
      q <= d;
    end
  end

  // checkpoint capture, data arrives one cycle after the read strobe
  // only listed items have slots
  always_ff @(posedge clk) begin
    if (q.cap_vld) begin
      ckpt_mem[q.cap_idx] <= rf_rd_data;
    end
  end

  // outputs
  assign rf_rd_en        = (q.state == TCR_SAVE) && !q.issue_done;
  assign rf_rd_idx       = q.idx;
  assign rf_wr_en        = q.rf_wr_en;
  assign rf_wr_idx       = q.rf_wr_idx;
  assign rf_wr_data      = q.rf_wr_data;
  assign busy            = (q.state != TCR_IDLE) && (q.state != TCR_TX);
  assign in_tx           = (q.state != TCR_IDLE);
  assign nest_depth      = q.depth;
  assign resume_vld      = q.resume_vld;
  assign resume_pc       = q.pc + 64'h0000_0000_0000_0004;
  assign stack_pointer_select_wr_grant  = stack_pointer_select_wr_req && (q.state == TCR_IDLE);
  assign mem_barrier_req = q.bar_req;
  assign tx_order_active = (q.state == TCR_TX) || (q.state == TCR_BAR_OUT);
  assign store_drain     = q.drain;
  assign store_discard   = q.discard;
  assign gmon_others_clr = q.gclr;
  assign lmon_open       = q.lmon;
  assign gmon_self_open  = q.gself;
  assign event_set       = q.evt;
  assign avs_readdata    = q.av_rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !q.av_ack;

endmodule : tcr_core

// *** test/tcr_core_sva.sv ***
// assertion checker for the checkpoint and restore block
`timescale 1ns/1ps
module tcr_core_sva (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // state and exit pulses
  input wire logic       busy,
  input wire logic       in_tx,
  input wire logic [7:0] nest_depth,
  input wire logic       resume_vld,
  input wire logic       rf_rd_en,
  input wire logic       rf_wr_en,
  input wire logic       stack_pointer_select_wr_req,
  input wire logic       stack_pointer_select_wr_grant,
  input wire logic       mem_barrier_req,
  input wire logic       mem_barrier_ack,
  input wire logic       store_drain,
  input wire logic       store_discard,
  input wire logic       gmon_others_clr,
  input wire logic       lmon_open,
  input wire logic       gmon_self_open,
  input wire logic       event_set
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_stack_pointer_select; stack_pointer_select_wr_grant == (stack_pointer_select_wr_req && !in_tx); endproperty
  a_stack_pointer_select: assert property (p_stack_pointer_select) else $error("stack_pointer_select grant in tx");
  property p_resume; resume_vld |-> nest_depth == 8'h00; endproperty
  a_resume: assert property (p_resume) else $error("depth not zero at resume");
  property p_discard; store_discard |=> !store_drain [*8]; endproperty
  a_discard: assert property (p_discard) else $error("drain after discard");
  property p_lmon; store_discard |-> lmon_open && gmon_self_open; endproperty
  a_lmon: assert property (p_lmon) else $error("monitor not opened on fail");
  property p_oclr; gmon_others_clr |-> store_drain; endproperty
  a_oclr: assert property (p_oclr) else $error("others cleared off commit");
  property p_evt; event_set |-> gmon_self_open; endproperty
  a_evt: assert property (p_evt) else $error("event without monitor open");
  property p_save; rf_rd_en |-> busy && nest_depth == 8'h00; endproperty
  a_save: assert property (p_save) else $error("save outside outer begin");
  property p_bar; mem_barrier_req && mem_barrier_ack |=> !mem_barrier_req; endproperty
  a_bar: assert property (p_bar) else $error("barrier held after ack");
  property p_rest; rf_wr_en |-> $past(busy) && $past(in_tx); endproperty
  a_rest: assert property (p_rest) else $error("restore write outside restore");
  // main scenarios reached
  c_drain: cover property (store_drain);
  c_discard: cover property (store_discard);
  c_event: cover property (event_set);
  c_resume: cover property (resume_vld);
endmodule : tcr_core_sva
bind tcr_core tcr_core_sva u_sva (.clk, .rst, .busy, .in_tx, .nest_depth, .resume_vld, .rf_rd_en, .rf_wr_en,
  .stack_pointer_select_wr_req, .stack_pointer_select_wr_grant, .mem_barrier_req, .mem_barrier_ack, .store_drain, .store_discard,
  .gmon_others_clr, .lmon_open, .gmon_self_open, .event_set);

// *** test/tcr_rf_model.sv ***
// register file and barrier model at the far side of the block
`timescale 1ns/1ps
module tcr_rf_model #(
  parameter int VL_MAX  = 256,
  parameter int BAR_LAT = 2
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // register file side
  input  wire logic              rf_rd_en,
  input  wire logic [6:0]        rf_rd_idx,
  output logic      [VL_MAX-1:0] rf_rd_data,
  input  wire logic              rf_wr_en,
  input  wire logic [6:0]        rf_wr_idx,
  input  wire logic [VL_MAX-1:0] rf_wr_data,
  // barrier handshake
  input  wire logic              mem_barrier_req,
  output logic                   mem_barrier_ack
);
  logic [VL_MAX-1:0] wr_mem [0:127];
  int                rd_cnt;
  int                wr_cnt;
  int                bar_cnt;
  // data valid one cycle after the read, inverted every cycle after, so stale data matches again every second cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      rf_rd_data <= '0;
    end else if (rf_rd_en) begin
      rf_rd_data <= {(VL_MAX/8){1'b1, rf_rd_idx}};
      rd_cnt     <= rd_cnt + 1;
    end else begin
      rf_rd_data <= ~rf_rd_data;
    end
    if (rf_wr_en) begin
      wr_mem[rf_wr_idx] <= rf_wr_data;
      wr_cnt            <= wr_cnt + 1;
    end
  end
  // slow barrier: ack pulse after BAR_LAT cycles of request
  always_ff @(posedge clk) begin
    bar_cnt         <= mem_barrier_req ? bar_cnt + 1 : 0;
    mem_barrier_ack <= !rst && mem_barrier_req && bar_cnt == BAR_LAT && !mem_barrier_ack;
  end
endmodule : tcr_rf_model

// *** test/tb.sv ***
// self-checking bench for the checkpoint and restore block
`timescale 1ns/1ps
module tb;
  import tcr_pkg::*;
  logic         clk, rst, avs_read, avs_write, avs_waitrequest, commit_order_viol, seen_clr, seen_ack;
  logic [4:0]   avs_address, begin_dest, ev_q, seen, pulses;
  logic [31:0]  avs_writedata, avs_readdata;
  logic [3:0]   avs_byteenable;
  logic [63:0]  begin_pc, fail_cause, resume_pc, rpc;
  logic [15:0]  abort_imm;
  logic [11:0]  cur_vl;
  logic [7:0]   nest_depth;
  logic [6:0]   rf_rd_idx, rf_wr_idx;
  logic [255:0] rf_rd_data, rf_wr_data;
  logic         fp_enabled, sve_enabled, busy, in_tx, resume_vld, rf_rd_en, rf_wr_en, stack_pointer_select_wr_req;
  logic         stack_pointer_select_wr_grant, mem_barrier_req, mem_barrier_ack, tx_order_active, store_drain;
  logic         store_discard, gmon_others_clr, lmon_open, gmon_self_open, own_gmon_excl, event_set;
  int           miscompares, check_count, cyc;
  // design and far-side model
  tcr_core #(.VL_MAX(256)) uut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .begin_instr(ev_q[4]), .begin_dest, .begin_pc,
    .commit_instr(ev_q[3]), .commit_order_viol, .abort_instr(ev_q[2]), .abort_imm, .fail_req(ev_q[1]),
    .fail_cause, .mem_conflict(ev_q[0]), .fp_enabled, .sve_enabled, .cur_vl, .busy, .in_tx, .nest_depth,
    .resume_vld, .resume_pc, .rf_rd_en, .rf_rd_idx, .rf_rd_data, .rf_wr_en, .rf_wr_idx, .rf_wr_data,
    .stack_pointer_select_wr_req, .stack_pointer_select_wr_grant, .mem_barrier_req, .mem_barrier_ack, .tx_order_active, .store_drain,
    .store_discard, .gmon_others_clr, .lmon_open, .gmon_self_open, .own_gmon_excl, .event_set);
  tcr_rf_model #(.VL_MAX(256), .BAR_LAT(2)) mdl (.clk, .rst, .rf_rd_en, .rf_rd_idx, .rf_rd_data,
    .rf_wr_en, .rf_wr_idx, .rf_wr_data, .mem_barrier_req, .mem_barrier_ack);
  task automatic print_verdict;
    if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic check(input string nm, input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  function automatic logic [63:0] pat64(input logic [6:0] i);
    return {8{1'b1, i}};
  endfunction : pat64
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // events only when the core is not stalled; extra edge lets pulses land
  task automatic wait_free;
    @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
    @(posedge clk);
  endtask : wait_free
  task automatic ev(input logic [4:0] e);
    wait_free();
    ev_q <= e;
    @(posedge clk);
    ev_q <= 5'h00;
    wait_free();
  endtask : ev
  task automatic t_regs;
    logic [31:0] d;
    bus(1'b0, TCR_OFF_CTRL, 32'h0000_0000, d);
    check("ctrl_reset", d, 32'h0000_0001);
    bus(1'b1, TCR_OFF_STATUS, 32'h0000_0FF7, d);
    bus(1'b0, TCR_OFF_STATUS, 32'h0000_0000, d);
    check("status_idle", d, 32'h0000_0000);
    bus(1'b0, 5'h14, 32'h0000_0000, d);
    check("unmapped", d, 32'h0000_0000);
  endtask : t_regs
  // nested begin and commit with own monitor exclusive
  task automatic t_commit;
    logic [31:0] d;
    int          r0;
    r0 = mdl.rd_cnt;
    seen_clr = !seen_clr;
    own_gmon_excl <= 1'b1;
    ev(5'h10);
    check("save_sve", 64'(mdl.rd_cnt - r0), 64'(TCR_ITEM_LAST_SVE) + 1);
    check("order_active", tx_order_active, 1'b1);
    stack_pointer_select_wr_req <= 1'b1;
    @(posedge clk);
    check("stack_pointer_select_tx", stack_pointer_select_wr_grant, 1'b0);
    stack_pointer_select_wr_req <= 1'b0;
    ev(5'h10);
    check("depth2", nest_depth, 8'h02);
    check("no_resave", 64'(mdl.rd_cnt - r0), 64'(TCR_ITEM_LAST_SVE) + 1);
    ev(5'h08);
    check("depth1", nest_depth, 8'h01);
    ev(5'h08);
    check("exit", {in_tx, nest_depth}, 9'h000);
    check("commit_pulses", seen[3:0], 4'b1101);
    bus(1'b0, TCR_OFF_COMMITS, 32'h0000_0000, d);
    check("commits", d, 32'h0000_0001);
    own_gmon_excl <= 1'b0;
  endtask : t_commit
  // memory conflict with vector unit off: simd restore, upper bits zeroed
  task automatic t_fail;
    int w0;
    w0 = mdl.wr_cnt;
    seen_clr = !seen_clr;
    sve_enabled <= 1'b0;
    ev(5'h10);
    ev(5'h01);
    check("restore_cnt", 64'(mdl.wr_cnt - w0), 64'(TCR_ITEM_LAST_SIMD) + 1);
    check("gpr0", mdl.wr_mem[0][63:0], pat64(7'h00));
    check("flags", mdl.wr_mem[33][63:0], pat64(7'h21));
    check("cause_mem", mdl.wr_mem[5][17:16], 2'b10);
    check("simd_lo", mdl.wr_mem[37][63:0], pat64(7'h25));
    check("simd_up", mdl.wr_mem[37][191:128], 64'h0000_0000_0000_0000);
    check("fail_pulses", {seen[4], seen[1:0]}, 3'b110);
    check("resume", rpc, 64'h0000_0000_0000_1004);
    check("depth0", nest_depth, 8'h00);
  endtask : t_fail
  // commit that would break ordering fails with memory cause
  task automatic t_viol;
    logic [31:0] d;
    seen_clr = !seen_clr;
    ev(5'h10);
    commit_order_viol <= 1'b1;
    ev(5'h08);
    commit_order_viol <= 1'b0;
    check("viol_pulses", seen[1:0], 2'b10);
    bus(1'b0, TCR_OFF_CAUSE, 32'h0000_0000, d);
    check("viol_cause", d[17:16], 2'b10);
    check("viol_rtry", d[15], 1'b1);
  endtask : t_viol
  // abort with short vector length and entry-value restore of upper bits
  task automatic t_abort;
    logic [31:0] d;
    bus(1'b1, TCR_OFF_CTRL, 32'h0000_0000, d);
    sve_enabled <= 1'b1;
    cur_vl      <= 12'h080;
    begin_dest  <= 5'h03;
    ev(5'h10);
    ev(5'h04);
    bus(1'b0, TCR_OFF_CAUSE, 32'h0000_0000, d);
    check("abort_cause", d, 32'h0001_8123);
    check("abort_dest", mdl.wr_mem[3][31:0], 32'h0001_8123);
    check("vec_up", mdl.wr_mem[37][255:192], pat64(7'h25));
    check("ffr", mdl.wr_mem[85][63:0], pat64(7'h55));
    bus(1'b0, TCR_OFF_FAILS, 32'h0000_0000, d);
    check("fails", d, 32'h0000_0003);
  endtask : t_abort
  // core-reported failure: cancel flag and reason field are not carried over
  task automatic t_freq;
    logic [31:0] d;
    seen_clr = !seen_clr;
    fail_cause <= 64'h0000_0000_0005_FFFF;
    ev(5'h10);
    ev(5'h02);
    bus(1'b0, TCR_OFF_CAUSE, 32'h0000_0000, d);
    check("freq_cause", d, 32'h0004_8000);
    check("freq_dest", mdl.wr_mem[3][31:0], 32'h0004_8000);
    check("freq_pulses", seen[1:0], 2'b10);
  endtask : t_freq
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  assign pulses = {resume_vld, event_set, gmon_others_clr, store_discard, store_drain};
  // cycle limit, sticky pulse flags and resume address capture
  always @(posedge clk) begin
    cyc      <= cyc + 1;
    seen_ack <= seen_clr;
    // tasks toggle seen_clr instead of writing seen, so no race with this process
    if (rst) seen <= 5'h00;
    else if (seen_clr != seen_ack) seen <= pulses;
    else seen <= seen | pulses;
    if (resume_vld === 1'b1) rpc <= resume_pc;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    {rst, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = {1'b1, 39'h0, 4'hF};
    {ev_q, commit_order_viol, own_gmon_excl, stack_pointer_select_wr_req, seen_clr} = '0;
    {begin_dest, begin_pc, abort_imm, fail_cause} = {5'h05, 64'h0000_0000_0000_1000, 16'h8123, 64'h0};
    {fp_enabled, sve_enabled, cur_vl, miscompares, check_count} = {2'b11, 12'h100, 64'h0};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_commit();
    t_fail();
    t_viol();
    t_abort();
    t_freq();
    print_verdict();
  end
endmodule : tb
